// *** hw/pae_pkg.sv ***
`default_nettype none

package pae_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int NCH  = 4;
	localparam int DW   = 16;
	localparam int EW   = 18;
	localparam int KW   = 5;
	localparam int SELW = 3;

	////////////////////////////////////////////////////////////////////////
	// Alarm type codes
	localparam logic [KW-1:0] TYPE_OFF          = 5'h00;
	localparam logic [KW-1:0] TYPE_BAND_OUT     = 5'h01;
	localparam logic [KW-1:0] TYPE_UPPER        = 5'h02;
	localparam logic [KW-1:0] TYPE_LOWER        = 5'h03;
	localparam logic [KW-1:0] TYPE_BAND_IN      = 5'h04;
	localparam logic [KW-1:0] TYPE_BAND_OUT_SB  = 5'h05;
	localparam logic [KW-1:0] TYPE_UPPER_SB     = 5'h06;
	localparam logic [KW-1:0] TYPE_LOWER_SB     = 5'h07;
	localparam logic [KW-1:0] TYPE_ABS_UPPER    = 5'h08;
	localparam logic [KW-1:0] TYPE_ABS_LOWER    = 5'h09;
	localparam logic [KW-1:0] TYPE_ABS_UPPER_SB = 5'h0a;
	localparam logic [KW-1:0] TYPE_ABS_LOWER_SB = 5'h0b;
	localparam logic [KW-1:0] TYPE_LOOP_BREAK   = 5'h0c;
	localparam logic [KW-1:0] TYPE_SP_UPPER     = 5'h0e;
	localparam logic [KW-1:0] TYPE_SP_LOWER     = 5'h0f;
	localparam logic [KW-1:0] TYPE_MV_UPPER     = 5'h10;

	////////////////////////////////////////////////////////////////////////
	// Assignments and reset values
	localparam int              LBA_CHANNEL = 0;
	localparam logic [SELW-1:0] SEL_NONE    = 3'h0;
	localparam logic [SELW-1:0] SEL_FIRST   = 3'h1;
	localparam logic [SELW-1:0] SEL_LAST    = 3'h4;
	localparam logic [DW-1:0]   RST_VALUE   = 16'h0064;
	localparam logic [DW-1:0]   RST_HYST    = 16'h0002;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic [KW-1:0]        kind;
		logic signed [DW-1:0] value;
		logic signed [DW-1:0] upper;
		logic signed [DW-1:0] lower;
		logic signed [DW-1:0] hyst;
	} pae_cfg_t;

	typedef struct packed {
		logic signed [DW-1:0] pv;
		logic signed [DW-1:0] sp;
		logic signed [DW-1:0] mv;
		logic signed [DW-1:0] heat_mv;
	} pae_proc_t;

	localparam pae_cfg_t RST_CFG = '{TYPE_UPPER, RST_VALUE, RST_VALUE, RST_VALUE, RST_HYST};

	typedef enum logic [3:0] {
		ST_OFF   = 4'b0001,
		ST_WAIT  = 4'b0010,
		ST_CLEAR = 4'b0100,
		ST_ON    = 4'b1000
	} pae_state_t;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic signed [EW-1:0] pae_ext(input logic signed [DW-1:0] v);
		return EW'(v);
	endfunction

	function automatic logic pae_has_standby(input logic [KW-1:0] k);
		return k == TYPE_BAND_OUT_SB || k == TYPE_UPPER_SB || k == TYPE_LOWER_SB
			|| k == TYPE_ABS_UPPER_SB || k == TYPE_ABS_LOWER_SB;
	endfunction

endpackage

`default_nettype wire

// *** hw/pae_channel.sv ***
`timescale 1ns/1ps
`default_nettype none

module pae_channel (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              reset_i,
	// Evaluation control
	input  wire logic              tick_i,
	input  wire logic              enable_i,
	input  wire logic              lba_ok_i,
	input  wire logic              standby_reset_i,
	input  wire logic              loop_break_i,
	input  wire logic              heat_cool_i,
	input  var  pae_pkg::pae_cfg_t  cfg_i,
	input  var  pae_pkg::pae_proc_t proc_i,
	// Result
	output logic                   alarm_o,
	output logic                   standby_o
);

	pae_pkg::pae_state_t state_r;
	pae_pkg::pae_state_t state_nxt;
	logic                enter;
	logic                stay;
	logic                live;
	logic                sby;

	////////////////////////////////////////////////////////////////////////
	// Region tests with hysteresis, loop break without
	always_comb begin
		logic signed [pae_pkg::EW-1:0] pv;
		logic signed [pae_pkg::EW-1:0] sp;
		logic signed [pae_pkg::EW-1:0] mv;
		logic signed [pae_pkg::EW-1:0] x;
		logic signed [pae_pkg::EW-1:0] h;
		logic signed [pae_pkg::EW-1:0] hi;
		logic signed [pae_pkg::EW-1:0] lo;
		pv = pae_pkg::pae_ext(proc_i.pv);
		sp = pae_pkg::pae_ext(proc_i.sp);
		mv = pae_pkg::pae_ext(heat_cool_i ? proc_i.heat_mv : proc_i.mv);
		x  = pae_pkg::pae_ext(cfg_i.value);
		h  = pae_pkg::pae_ext(cfg_i.hyst);
		hi = sp + pae_pkg::pae_ext(cfg_i.upper);
		lo = sp - pae_pkg::pae_ext(cfg_i.lower);
		enter = 1'b0;
		stay  = 1'b0;
		case (cfg_i.kind)
			pae_pkg::TYPE_BAND_OUT, pae_pkg::TYPE_BAND_OUT_SB: begin
				enter = pv >= hi || pv <= lo;
				stay  = pv >= hi - h || pv <= lo + h;
			end
			pae_pkg::TYPE_UPPER, pae_pkg::TYPE_UPPER_SB: begin
				enter = pv >= sp + x;
				stay  = pv >= sp + x - h;
			end
			pae_pkg::TYPE_LOWER, pae_pkg::TYPE_LOWER_SB: begin
				enter = pv <= sp - x;
				stay  = pv <= sp - x + h;
			end
			pae_pkg::TYPE_BAND_IN: begin
				enter = pv < hi && pv > lo;
				stay  = pv < hi + h && pv > lo - h;
			end
			pae_pkg::TYPE_ABS_UPPER, pae_pkg::TYPE_ABS_UPPER_SB: begin
				enter = pv > x;
				stay  = pv > x - h;
			end
			pae_pkg::TYPE_ABS_LOWER, pae_pkg::TYPE_ABS_LOWER_SB: begin
				enter = pv < x;
				stay  = pv < x + h;
			end
			pae_pkg::TYPE_LOOP_BREAK: begin
				enter = lba_ok_i && loop_break_i;
				stay  = enter;
			end
			pae_pkg::TYPE_SP_UPPER: begin
				enter = sp > x;
				stay  = sp > x - h;
			end
			pae_pkg::TYPE_SP_LOWER: begin
				enter = sp < x;
				stay  = sp < x + h;
			end
			pae_pkg::TYPE_MV_UPPER: begin
				enter = mv > x;
				stay  = mv > x - h;
			end
			default: begin
				enter = 1'b0;
				stay  = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Alarm and standby sequence
	assign sby  = pae_pkg::pae_has_standby(cfg_i.kind);
	assign live = enable_i && cfg_i.kind != pae_pkg::TYPE_OFF
		&& !(cfg_i.kind == pae_pkg::TYPE_LOOP_BREAK && !lba_ok_i);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			pae_pkg::ST_OFF:   if (tick_i) begin
				state_nxt = sby ? pae_pkg::ST_WAIT : (enter ? pae_pkg::ST_ON : pae_pkg::ST_CLEAR);
			end
			pae_pkg::ST_WAIT:  if (tick_i && !stay) begin
				state_nxt = pae_pkg::ST_CLEAR;
			end
			pae_pkg::ST_CLEAR: if (tick_i && enter) begin
				state_nxt = pae_pkg::ST_ON;
			end
			pae_pkg::ST_ON:    if (tick_i && !stay) begin
				state_nxt = pae_pkg::ST_CLEAR;
			end
			default: state_nxt = pae_pkg::ST_OFF;
		endcase
		if (standby_reset_i && sby && state_r != pae_pkg::ST_OFF) begin
			state_nxt = pae_pkg::ST_WAIT;
		end
		if (!live) begin
			state_nxt = pae_pkg::ST_OFF;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_r <= pae_pkg::ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign alarm_o   = state_r[3];
	assign standby_o = state_r[1];

endmodule

`default_nettype wire

// *** hw/pae_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module pae_top (
	// Clock and reset
	input  wire logic                          ref_clk_i,
	input  wire logic                          reset_i,
	// Sampling cycle
	input  wire logic                          sample_tick_i,
	// Channel configuration
	input  wire logic [pae_pkg::NCH-1:0]       cfg_wr_i,
	input  var  pae_pkg::pae_cfg_t             cfg_i,
	input  wire logic [pae_pkg::NCH-1:0]       standby_reset_i,
	// Control loop values
	input  var  pae_pkg::pae_proc_t            proc_i,
	input  wire logic                          heat_cool_i,
	input  wire logic                          loop_break_i,
	// Heater fault detection
	input  wire logic                          heater_fault_detect_i,
	input  wire logic                          heater_alarm_i,
	input  wire logic                          aux1_alarm_assign_i,
	// Control output assignment
	input  wire logic [pae_pkg::SELW-1:0]      ctrl1_assign_i,
	input  wire logic [pae_pkg::SELW-1:0]      ctrl2_assign_i,
	input  wire logic [1:0]                    ctrl_drive_i,
	// Outputs
	output logic [pae_pkg::NCH-1:0]            aux_o,
	output logic [1:0]                         ctrl_out_o,
	output logic [pae_pkg::NCH-1:0]            alarm_state_o,
	output logic [pae_pkg::NCH-1:0]            standby_o
);

	pae_pkg::pae_cfg_t              cfg_r   [pae_pkg::NCH];
	pae_pkg::pae_cfg_t              cfg_nxt [pae_pkg::NCH];
	logic [pae_pkg::NCH-1:0]        en;
	logic [pae_pkg::NCH-1:0]        alm;
	logic [pae_pkg::NCH-1:0]        stb;
	logic [pae_pkg::NCH-1:0]        aux_r;
	logic [pae_pkg::NCH-1:0]        aux_nxt;
	logic [1:0]                     ctrl_r;
	logic [1:0]                     ctrl_nxt;
	logic [pae_pkg::NCH-1:0]        state_r;
	logic [pae_pkg::NCH-1:0]        stb_r;
	logic                           heater_owns_aux1;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic sel_valid(input logic [pae_pkg::SELW-1:0] sel);
		return sel >= pae_pkg::SEL_FIRST && sel <= pae_pkg::SEL_LAST;
	endfunction

	function automatic logic pick(input logic [pae_pkg::SELW-1:0] sel,
		input logic [pae_pkg::NCH-1:0] alarms, input logic drive);
		logic [1:0] idx;
		idx = 2'(sel - pae_pkg::SEL_FIRST);
		return sel_valid(sel) ? alarms[idx] : drive;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Configuration per channel
	always_comb begin
		for (int i = 0; i < pae_pkg::NCH; i++) begin
			cfg_nxt[i] = cfg_r[i];
			if (cfg_wr_i[i]) begin
				cfg_nxt[i].value = cfg_i.value;
				cfg_nxt[i].upper = cfg_i.upper;
				cfg_nxt[i].lower = cfg_i.lower;
				cfg_nxt[i].hyst  = cfg_i.hyst;
				if (cfg_i.kind <= pae_pkg::TYPE_MV_UPPER
					&& !(cfg_i.kind == pae_pkg::TYPE_LOOP_BREAK
					&& i != pae_pkg::LBA_CHANNEL)) begin
					cfg_nxt[i].kind = cfg_i.kind;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < pae_pkg::NCH; i++) begin
			if (reset_i) begin
				cfg_r[i] <= pae_pkg::RST_CFG;
			end else begin
				cfg_r[i] <= cfg_nxt[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel enables
	assign heater_owns_aux1 = heater_fault_detect_i && !aux1_alarm_assign_i;

	always_comb begin
		en    = '1;
		en[0] = !heater_owns_aux1
			|| ctrl1_assign_i == pae_pkg::SEL_FIRST
			|| ctrl2_assign_i == pae_pkg::SEL_FIRST;
	end

	////////////////////////////////////////////////////////////////////////
	// Channels
	for (genvar g = 0; g < pae_pkg::NCH; g++) begin : g_ch
		pae_channel u_ch (
			.ref_clk_i       (ref_clk_i),
			.reset_i         (reset_i),
			.tick_i          (sample_tick_i),
			.enable_i        (en[g]),
			.lba_ok_i        (g == pae_pkg::LBA_CHANNEL),
			.standby_reset_i (standby_reset_i[g]),
			.loop_break_i    (loop_break_i),
			.heat_cool_i     (heat_cool_i),
			.cfg_i           (cfg_r[g]),
			.proc_i          (proc_i),
			.alarm_o         (alm[g]),
			.standby_o       (stb[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// Output routing
	always_comb begin
		aux_nxt = alm;
		if (heater_owns_aux1) begin
			aux_nxt[0] = heater_alarm_i;
		end
		ctrl_nxt[0] = pick(ctrl1_assign_i, alm, ctrl_drive_i[0]);
		ctrl_nxt[1] = pick(ctrl2_assign_i, alm, ctrl_drive_i[1]);
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			aux_r   <= '0;
			ctrl_r  <= '0;
			state_r <= '0;
			stb_r   <= '0;
		end else begin
			aux_r   <= aux_nxt;
			ctrl_r  <= ctrl_nxt;
			state_r <= alm;
			stb_r   <= stb;
		end
	end

	assign aux_o         = aux_r;
	assign ctrl_out_o    = ctrl_r;
	assign alarm_state_o = state_r;
	assign standby_o     = stb_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	logic signed [pae_pkg::EW-1:0] pv_e;
	logic signed [pae_pkg::EW-1:0] sp_e;
	logic signed [pae_pkg::EW-1:0] hmv_e;
	logic signed [pae_pkg::EW-1:0] mv_e;
	assign mv_e  = pae_pkg::pae_ext(proc_i.mv);
	assign pv_e  = pae_pkg::pae_ext(proc_i.pv);
	assign sp_e  = pae_pkg::pae_ext(proc_i.sp);
	assign hmv_e = pae_pkg::pae_ext(proc_i.heat_mv);

	property p_type_off;
		(cfg_r[2].kind == pae_pkg::TYPE_OFF)[*2] |=> !alarm_state_o[2];
	endproperty
	a_type_off: assert property (p_type_off) else $error("alarm on with type off");

	property p_upper;
		sample_tick_i && cfg_r[1].kind == pae_pkg::TYPE_UPPER
			&& pv_e >= sp_e + pae_pkg::pae_ext(cfg_r[1].value) |=> alm[1] ##1 alarm_state_o[1];
	endproperty
	a_upper: assert property (p_upper) else $error("upper deviation alarm missed");

	property p_lower;
		sample_tick_i && cfg_r[2].kind == pae_pkg::TYPE_LOWER
			&& pv_e <= sp_e - pae_pkg::pae_ext(cfg_r[2].value) |=> alm[2];
	endproperty
	a_lower: assert property (p_lower) else $error("lower deviation alarm missed");

	property p_abs_upper;
		sample_tick_i && cfg_r[2].kind == pae_pkg::TYPE_ABS_UPPER
			&& pv_e > pae_pkg::pae_ext(cfg_r[2].value) |=> alm[2];
	endproperty
	a_abs_upper: assert property (p_abs_upper) else $error("absolute upper alarm missed");

	property p_abs_lower;
		sample_tick_i && cfg_r[2].kind == pae_pkg::TYPE_ABS_LOWER
			&& pv_e < pae_pkg::pae_ext(cfg_r[2].value) |=> alm[2];
	endproperty
	a_abs_lower: assert property (p_abs_lower) else $error("absolute lower alarm missed");

	property p_sp_upper;
		sample_tick_i && cfg_r[2].kind == pae_pkg::TYPE_SP_UPPER
			&& sp_e > pae_pkg::pae_ext(cfg_r[2].value) |=> alm[2];
	endproperty
	a_sp_upper: assert property (p_sp_upper) else $error("setpoint upper alarm missed");

	property p_mv_heat;
		sample_tick_i && heat_cool_i && cfg_r[2].kind == pae_pkg::TYPE_MV_UPPER
			&& hmv_e > pae_pkg::pae_ext(cfg_r[2].value) |=> alm[2];
	endproperty
	a_mv_heat: assert property (p_mv_heat) else $error("heating output alarm missed");

	property p_hold;
		!sample_tick_i && !standby_reset_i[2] && cfg_r[2].kind != pae_pkg::TYPE_OFF
			##1 cfg_r[2].kind != pae_pkg::TYPE_OFF |-> $stable(alm[2]);
	endproperty
	a_hold: assert property (p_hold) else $error("alarm changed between samples");

	property p_no_lba;
		cfg_r[2].kind != pae_pkg::TYPE_LOOP_BREAK && cfg_r[3].kind != pae_pkg::TYPE_LOOP_BREAK;
	endproperty
	a_no_lba: assert property (p_no_lba) else $error("loop break type on wrong channel");

	property p_heater;
		(heater_owns_aux1 && ctrl1_assign_i != pae_pkg::SEL_FIRST
			&& ctrl2_assign_i != pae_pkg::SEL_FIRST)[*2]
			|=> !alarm_state_o[0] && aux_o[0] == $past(heater_alarm_i);
	endproperty
	a_heater: assert property (p_heater) else $error("heater default assignment broken");

	property p_ctrl_route;
		ctrl1_assign_i == 3'h3 |=> ctrl_out_o[0] == $past(alm[2]);
	endproperty
	a_ctrl_route: assert property (p_ctrl_route) else $error("control output routing wrong");

	sequence s_arm;
		standby_reset_i[3] && !cfg_wr_i[3] && alm[3]
			&& cfg_r[3].kind == pae_pkg::TYPE_UPPER_SB;
	endsequence

	sequence s_gap;
		!sample_tick_i && !cfg_wr_i[3];
	endsequence

	sequence s_still_in;
		sample_tick_i && !cfg_wr_i[3] && pv_e >= sp_e + pae_pkg::pae_ext(cfg_r[3].value);
	endsequence

	property p_standby;
		s_arm ##1 s_gap ##1 s_still_in |=> stb[3] && !alm[3];
	endproperty
	a_standby: assert property (p_standby) else $error("standby did not suppress alarm");

	sequence s_sb_out;
		sample_tick_i && stb[3] && !standby_reset_i[3] && !cfg_wr_i[3]
			&& cfg_r[3].kind == pae_pkg::TYPE_UPPER_SB;
	endsequence

	property p_sb_leave;
		s_sb_out and (pv_e < sp_e + pae_pkg::pae_ext(cfg_r[3].value)
			- pae_pkg::pae_ext(cfg_r[3].hyst)) |=> !stb[3];
	endproperty
	a_sb_leave: assert property (p_sb_leave) else $error("standby wait not left");

	property p_band_out;
		sample_tick_i && cfg_r[2].kind == pae_pkg::TYPE_BAND_OUT
			&& (pv_e >= sp_e + pae_pkg::pae_ext(cfg_r[2].upper)
			|| pv_e <= sp_e - pae_pkg::pae_ext(cfg_r[2].lower)) |=> alm[2];
	endproperty
	a_band_out: assert property (p_band_out) else $error("band outside alarm missed");

	property p_band_in;
		sample_tick_i && cfg_r[2].kind == pae_pkg::TYPE_BAND_IN
			&& pv_e < sp_e + pae_pkg::pae_ext(cfg_r[2].upper)
			&& pv_e > sp_e - pae_pkg::pae_ext(cfg_r[2].lower) |=> alm[2];
	endproperty
	a_band_in: assert property (p_band_in) else $error("band inside alarm missed");

	property p_sp_lower;
		sample_tick_i && cfg_r[2].kind == pae_pkg::TYPE_SP_LOWER
			&& sp_e < pae_pkg::pae_ext(cfg_r[2].value) |=> alm[2];
	endproperty
	a_sp_lower: assert property (p_sp_lower) else $error("setpoint lower alarm missed");

	property p_mv_upper;
		sample_tick_i && !heat_cool_i && cfg_r[2].kind == pae_pkg::TYPE_MV_UPPER
			&& mv_e > pae_pkg::pae_ext(cfg_r[2].value) |=> alm[2];
	endproperty
	a_mv_upper: assert property (p_mv_upper) else $error("manipulated upper alarm missed");

	property p_lba;
		sample_tick_i && en[0] && loop_break_i
			&& cfg_r[0].kind == pae_pkg::TYPE_LOOP_BREAK |=> alm[0];
	endproperty
	a_lba: assert property (p_lba) else $error("loop break alarm missed");

	property p_ctrl2_route;
		ctrl2_assign_i == pae_pkg::SEL_FIRST |=> ctrl_out_o[1] == $past(alm[0]);
	endproperty
	a_ctrl2_route: assert property (p_ctrl2_route) else $error("second control routing wrong");

	property p_aux_route;
		!heater_owns_aux1 |=> aux_o == $past(alm);
	endproperty
	a_aux_route: assert property (p_aux_route) else $error("aux output routing wrong");

endmodule

`default_nettype wire

// *** verif/pae_relay_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pae_relay_model (
	// Clock
	input  wire logic       ref_clk_i,
	// Driven outputs
	input  wire logic [3:0] aux_i,
	input  wire logic [1:0] ctrl_i,
	// Contact states
	output logic [5:0]      contacts_o
);
	// Contacts follow the drive one clock later
	always_ff @(posedge ref_clk_i) begin
		contacts_o <= {ctrl_i, aux_i};
	end
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic               ref_clk_i, reset_i, sample_tick_i;
	logic [3:0]         cfg_wr_i, standby_reset_i;
	pae_pkg::pae_cfg_t  cfg_i;
	pae_pkg::pae_proc_t proc_i;
	logic               heat_cool_i, loop_break_i;
	logic               heater_fault_detect_i, heater_alarm_i, aux1_alarm_assign_i;
	logic [2:0]         ctrl1_assign_i, ctrl2_assign_i;
	logic [1:0]         ctrl_drive_i, ctrl_out_o;
	logic [3:0]         aux_o, alarm_state_o, standby_o;
	logic [5:0]         contacts;
	int                 err_count, n_tests;

	pae_top u_dut (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sample_tick_i(sample_tick_i),
		.cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i), .standby_reset_i(standby_reset_i),
		.proc_i(proc_i), .heat_cool_i(heat_cool_i), .loop_break_i(loop_break_i),
		.heater_fault_detect_i(heater_fault_detect_i), .heater_alarm_i(heater_alarm_i),
		.aux1_alarm_assign_i(aux1_alarm_assign_i), .ctrl1_assign_i(ctrl1_assign_i),
		.ctrl2_assign_i(ctrl2_assign_i), .ctrl_drive_i(ctrl_drive_i), .aux_o(aux_o),
		.ctrl_out_o(ctrl_out_o), .alarm_state_o(alarm_state_o), .standby_o(standby_o)
	);

	pae_relay_model u_relay (
		.ref_clk_i(ref_clk_i), .aux_i(aux_o), .ctrl_i(ctrl_out_o), .contacts_o(contacts)
	);

	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic check(input logic [5:0] seen, input logic [5:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	task automatic wr(input logic [3:0] ch, input logic [4:0] k, input logic [15:0] x);
		cyc(1);
		cfg_i <= '{k, x, 16'h0014, 16'h000a, 16'h0000};
		cfg_wr_i <= ch;
		cyc(1);
		cfg_wr_i <= 4'h0;
	endtask

	// Tick with given values, then look at settled ports
	task automatic tick(input logic [15:0] pv, input logic [15:0] sp, input logic [15:0] mv);
		cyc(1);
		proc_i.pv <= pv;
		proc_i.sp <= sp;
		proc_i.mv <= mv;
		sample_tick_i <= 1'b1;
		cyc(1);
		sample_tick_i <= 1'b0;
		cyc(2);
		@(negedge ref_clk_i);
	endtask

	task automatic tally_and_finish;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic defaults;
		@(negedge ref_clk_i);
		check({ctrl_out_o, aux_o}, 6'h00);
		tick(16'h0063, 16'h0000, 16'h0000);
		check({2'h0, alarm_state_o}, 6'h00);
		tick(16'h0064, 16'h0000, 16'h0000);
		check({2'h0, alarm_state_o}, 6'h0f);
		tick(16'h0063, 16'h0000, 16'h0000);
		check({2'h0, aux_o}, 6'h0f);
		tick(16'h0061, 16'h0000, 16'h0000);
		check({2'h0, aux_o}, 6'h00);
	endtask

	task automatic chk_type(input logic [4:0] k, input logic [15:0] pv,
			input logic [15:0] sp, input logic [15:0] mv, input logic e);
		wr(4'h4, k, 16'h0032);
		tick(pv, sp, mv);
		check({4'h0, alarm_state_o[2], aux_o[2]}, {4'h0, e, e});
	endtask

	task automatic types;
		chk_type(5'h01, 16'h0078, 16'h0064, 16'h0000, 1'b1);
		chk_type(5'h01, 16'h0073, 16'h0064, 16'h0000, 1'b0);
		chk_type(5'h01, 16'h005a, 16'h0064, 16'h0000, 1'b1);
		chk_type(5'h02, 16'h0096, 16'h0064, 16'h0000, 1'b1);
		chk_type(5'h02, 16'h0095, 16'h0064, 16'h0000, 1'b0);
		chk_type(5'h03, 16'h0032, 16'h0064, 16'h0000, 1'b1);
		chk_type(5'h03, 16'h0033, 16'h0064, 16'h0000, 1'b0);
		chk_type(5'h04, 16'h0069, 16'h0064, 16'h0000, 1'b1);
		chk_type(5'h04, 16'h0078, 16'h0064, 16'h0000, 1'b0);
		chk_type(5'h08, 16'h0033, 16'h0064, 16'h0000, 1'b1);
		chk_type(5'h08, 16'h0032, 16'h0064, 16'h0000, 1'b0);
		chk_type(5'h09, 16'h0031, 16'h0064, 16'h0000, 1'b1);
		chk_type(5'h09, 16'h0032, 16'h0064, 16'h0000, 1'b0);
		chk_type(5'h0e, 16'h0000, 16'h0033, 16'h0000, 1'b1);
		chk_type(5'h0e, 16'h0000, 16'h0032, 16'h0000, 1'b0);
		chk_type(5'h0f, 16'h0000, 16'h0031, 16'h0000, 1'b1);
		chk_type(5'h0f, 16'h0000, 16'h0032, 16'h0000, 1'b0);
		chk_type(5'h10, 16'h0000, 16'h0064, 16'h0032, 1'b0);
		chk_type(5'h10, 16'h0000, 16'h0064, 16'h0033, 1'b1);
		chk_type(5'h00, 16'h00c8, 16'h0064, 16'h00c8, 1'b0);
		chk_type(5'h0d, 16'h00c8, 16'h0064, 16'h00c8, 1'b0);
		cyc(1);
		heat_cool_i <= 1'b1;
		proc_i.heat_mv <= 16'h003c;
		chk_type(5'h10, 16'h0000, 16'h0064, 16'h0000, 1'b1);
		cyc(1);
		heat_cool_i <= 1'b0;
		chk_type(5'h10, 16'h0000, 16'h0064, 16'h0000, 1'b0);
	endtask

	// Standby types on channel 3: in-region and out-of-region values
	task automatic sb(input logic [4:0] k, input logic [15:0] pin, input logic [15:0] pout);
		wr(4'h8, 5'h00, 16'h0032);
		tick(pout, 16'h0064, 16'h0000);
		wr(4'h8, k, 16'h0032);
		tick(pin, 16'h0064, 16'h0000);
		check({4'h0, alarm_state_o[3], standby_o[3]}, 6'h01);
		tick(pout, 16'h0064, 16'h0000);
		check({4'h0, alarm_state_o[3], standby_o[3]}, 6'h00);
		tick(pin, 16'h0064, 16'h0000);
		check({4'h0, alarm_state_o[3], aux_o[3]}, 6'h03);
		cyc(1);
		standby_reset_i <= 4'h8;
		cyc(1);
		standby_reset_i <= 4'h0;
		tick(pin, 16'h0064, 16'h0000);
		check({4'h0, alarm_state_o[3], standby_o[3]}, 6'h01);
	endtask

	task automatic standby_all;
		sb(5'h05, 16'h0082, 16'h0064);
		sb(5'h06, 16'h00c8, 16'h0064);
		sb(5'h07, 16'h0000, 16'h0064);
		sb(5'h0a, 16'h003c, 16'h0028);
		sb(5'h0b, 16'h0028, 16'h003c);
	endtask

	task automatic loop_break;
		wr(4'h1, 5'h0c, 16'h0000);
		wr(4'h2, 5'h08, 16'h0032);
		wr(4'h2, 5'h0c, 16'h0032);
		cyc(1);
		loop_break_i <= 1'b1;
		tick(16'h0000, 16'h0000, 16'h0000);
		check({4'h0, alarm_state_o[1:0]}, 6'h01);
		tick(16'h003c, 16'h0000, 16'h0000);
		check({4'h0, alarm_state_o[1:0]}, 6'h03);
		cyc(1);
		loop_break_i <= 1'b0;
	endtask

	task automatic assign_codes;
		logic e0;
		logic e1;
		wr(4'h1, 5'h08, 16'h000a);
		wr(4'h2, 5'h08, 16'h0014);
		wr(4'h4, 5'h08, 16'h001e);
		wr(4'h8, 5'h08, 16'h0028);
		tick(16'h0019, 16'h0000, 16'h0000);
		check({2'h0, aux_o}, 6'h03);
		for (int c = 0; c < 8; c++) begin
			cyc(1);
			ctrl1_assign_i <= 3'(c);
			ctrl2_assign_i <= 3'(c);
			ctrl_drive_i <= 2'b01;
			cyc(3);
			@(negedge ref_clk_i);
			e0 = (c >= 1 && c <= 4) ? (c <= 2) : 1'b1;
			e1 = (c >= 1 && c <= 4) ? (c <= 2) : 1'b0;
			check({4'h0, ctrl_out_o}, {4'h0, e1, e0});
			check(contacts, {e1, e0, 4'h3});
		end
		cyc(1);
		proc_i.pv <= 16'h0000;
		cyc(5);
		@(negedge ref_clk_i);
		check({2'h0, aux_o}, 6'h03);
		tick(16'h0000, 16'h0000, 16'h0000);
		check({2'h0, aux_o}, 6'h00);
	endtask

	task automatic heater;
		wr(4'h1, 5'h08, 16'h000a);
		cyc(1);
		ctrl1_assign_i <= 3'h0;
		ctrl2_assign_i <= 3'h0;
		heater_fault_detect_i <= 1'b1;
		heater_alarm_i <= 1'b1;
		tick(16'h0019, 16'h0000, 16'h0000);
		check({4'h0, alarm_state_o[0], aux_o[0]}, 6'h01);
		cyc(1);
		heater_alarm_i <= 1'b0;
		cyc(2);
		@(negedge ref_clk_i);
		check({5'h0, aux_o[0]}, 6'h00);
		cyc(1);
		aux1_alarm_assign_i <= 1'b1;
		tick(16'h0019, 16'h0000, 16'h0000);
		check({4'h0, alarm_state_o[0], aux_o[0]}, 6'h03);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock, watchdog, main sequence
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	initial begin
		cyc(20000);
		err_count++;
		tally_and_finish();
	end

	initial begin
		err_count = 0;
		n_tests = 0;
		reset_i = 1'b1;
		sample_tick_i = 1'b0;
		cfg_wr_i = 4'h0;
		cfg_i = pae_pkg::RST_CFG;
		standby_reset_i = 4'h0;
		proc_i = '0;
		heat_cool_i = 1'b0;
		loop_break_i = 1'b0;
		heater_fault_detect_i = 1'b0;
		heater_alarm_i = 1'b0;
		aux1_alarm_assign_i = 1'b0;
		ctrl1_assign_i = 3'h0;
		ctrl2_assign_i = 3'h0;
		ctrl_drive_i = 2'b00;
		cyc(20);
		reset_i <= 1'b0;
		defaults();
		types();
		standby_all();
		loop_break();
		assign_codes();
		heater();
		tally_and_finish();
	end
endmodule

`default_nettype wire
